/* acsp_consts.svh */
// Constants of the serial conversion port: frame slots and timing figures.
// Assumes it is included by bare name into the package and the design module.
`ifndef ACSP_CONSTS_SVH
`define ACSP_CONSTS_SVH

`define ACSP_RES_BITS      10
`define ACSP_CNT_W         5
`define ACSP_EDGE_FIRST    5'h01
`define ACSP_EDGE_MSB      5'h04
`define ACSP_EDGE_LSB      5'h0D
`define ACSP_EDGE_SUB_UP   5'h0E
`define ACSP_EDGE_SUB_LO   5'h0F
`define ACSP_EDGE_END      5'h10
`define ACSP_EDGE_AFTER    5'h11
`define ACSP_EDGE_TRACK    5'h0E
`define ACSP_TRIAL_MSB     10'h200
`define ACSP_ACQ_NS        125
`define ACSP_SCLK_NS       48
`define ACSP_ACQ_CYCLES    ((`ACSP_ACQ_NS + `ACSP_SCLK_NS - 1) / `ACSP_SCLK_NS)

`endif

/* acsp_pkg.sv */
// Types shared by the serial conversion port.
// Assumes acsp_consts.svh is on the include path.
`include "acsp_consts.svh"

package acsp_pkg;

  // Power state, Gray coded along normal, partial, full.
  typedef enum logic [1:0]
  {
    ACSP_PWR_NORMAL  = 2'h0,
    ACSP_PWR_PARTIAL = 2'h1,
    ACSP_PWR_FULL    = 2'h3
  } acsp_pwr_t;

  // One finished conversion: result word and the two sub-bits.
  typedef struct packed
  {
    logic [`ACSP_RES_BITS-1:0] data;
    logic                      sub_bit_upper;
    logic                      sub_bit_lower;
  } acsp_result_t;

endpackage

/* acsp_port.sv */
// Control and serial output of a 10-bit successive-approximation converter.
// Assumes conv_start_n_i is launched by the host on its serial clock, so it is
// sampled directly on sclk_i; comp_i comes from the comparator clocked by sclk_i.
`timescale 1ns/1ps
`include "acsp_consts.svh"

module acsp_port
(
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      sclk_i,
  input  wire logic                      conv_start_n_i,
  input  wire logic                      comp_i,
  output logic                           sdo_o,
  output logic                           sdo_oe_o,
  output logic                           hold_o,
  output logic [`ACSP_RES_BITS-1:0]      trial_o,
  output logic                           ref_en_o,
  output acsp_pkg::acsp_result_t         result_o,
  output logic                           result_valid_o,
  output acsp_pkg::acsp_pwr_t            pwr_state_o,
  output logic                           cal_done_o
);

  // Reset brought into the link domain through two flip-flops.
  logic rst_meta;
  logic srst_n;

  always_ff @(posedge sclk_i)
  begin
    rst_meta <= rst_n_i;
    srst_n   <= rst_meta;
  end

  // Link-domain state.
  logic                           cs_prev, next_cs_prev;
  logic                           active, next_active;
  logic [`ACSP_CNT_W-1:0]         cnt, next_cnt;
  logic                           hold, next_hold;
  logic [`ACSP_RES_BITS-1:0]      trial, next_trial;
  logic [`ACSP_RES_BITS-1:0]      res, next_res;
  logic                           sub_u, next_sub_u;
  logic                           sub_l, next_sub_l;
  logic                           sdo, next_sdo;
  logic                           oe, next_oe;
  logic                           cont, next_cont;
  acsp_pkg::acsp_pwr_t            pwr, next_pwr;
  logic                           cal, next_cal;
  logic                           rtgl, next_rtgl;
  acsp_pkg::acsp_result_t         cap, next_cap;
  logic                           start;
  logic [`ACSP_CNT_W-1:0]         c;
  logic [3:0]                     idx;

  // Frame sequencer: counts rising edges and steers output, conversion and power.
  always_comb
  begin
    next_cs_prev = conv_start_n_i;
    next_active  = active;
    next_cnt     = cnt;
    next_hold    = hold;
    next_trial   = trial;
    next_res     = res;
    next_sub_u   = sub_u;
    next_sub_l   = sub_l;
    next_sdo     = sdo;
    next_oe      = oe;
    next_cont    = cont;
    next_pwr     = pwr;
    next_cal     = cal;
    next_rtgl    = rtgl;
    next_cap     = cap;
    start        = !conv_start_n_i && cs_prev;
    c            = (cnt == `ACSP_EDGE_AFTER) ? cnt : cnt + `ACSP_EDGE_FIRST;
    idx          = 4'(`ACSP_EDGE_LSB - c);
    if (start)
    begin
      next_cnt    = `ACSP_EDGE_FIRST;
      next_active = 1'b1;
      next_hold   = 1'b1;
      next_oe     = 1'b1;
      next_sdo    = 1'b0;
      next_trial  = `ACSP_TRIAL_MSB;
      next_res    = '0;
      next_cont   = 1'b0;
    end
    else if (active)
    begin
      next_cnt = c;
      if (c >= `ACSP_EDGE_MSB && c <= `ACSP_EDGE_LSB)
      begin
        // Decide one bit per edge and present it at once.
        next_res[idx] = comp_i;
        next_sdo      = comp_i;
        next_trial    = next_res;
        if (c != `ACSP_EDGE_LSB)
        begin
          next_trial[idx - 4'h1] = 1'b1;
        end
        if (conv_start_n_i)
        begin
          // Early raise aborts and steps down the power state.
          next_active = 1'b0;
          next_hold   = 1'b0;
          next_oe     = 1'b0;
          next_sdo    = 1'b0;
          next_pwr    = (pwr == acsp_pkg::ACSP_PWR_NORMAL) ? acsp_pkg::ACSP_PWR_PARTIAL
                                                           : acsp_pkg::ACSP_PWR_FULL;
        end
      end
      else if (c == `ACSP_EDGE_SUB_UP)
      begin
        next_sub_u = comp_i;
        next_sdo   = comp_i;
        next_hold  = 1'b0;
      end
      else if (c == `ACSP_EDGE_SUB_LO)
      begin
        next_sub_l = comp_i;
        next_sdo   = comp_i;
      end
      else if (c == `ACSP_EDGE_END)
      begin
        next_sdo = 1'b0;
        if (pwr == acsp_pkg::ACSP_PWR_NORMAL)
        begin
          next_cap.data          = res;
          next_cap.sub_bit_upper = sub_u;
          next_cap.sub_bit_lower = sub_l;
          next_rtgl              = !rtgl;
          next_cal               = 1'b1;
        end
      end
      else if (c == `ACSP_EDGE_AFTER)
      begin
        next_active = 1'b0;
        if (!cont)
        begin
          next_oe = 1'b0;
        end
      end
      if (conv_start_n_i && c >= `ACSP_EDGE_TRACK && c <= `ACSP_EDGE_END)
      begin
        next_cont = 1'b1;
        next_pwr  = acsp_pkg::ACSP_PWR_NORMAL;
      end
    end
    else if (conv_start_n_i && oe && !cont)
    begin
      next_oe = 1'b0;
    end
  end

  // Link-domain registers; reset leaves the track/hold tracking.
  always_ff @(posedge sclk_i)
  begin
    if (!srst_n)
    begin
      cs_prev <= 1'b1;
      active  <= 1'b0;
      cnt     <= '0;
      hold    <= 1'b0;
      trial   <= '0;
      res     <= '0;
      sub_u   <= 1'b0;
      sub_l   <= 1'b0;
      sdo     <= 1'b0;
      oe      <= 1'b0;
      cont    <= 1'b0;
      pwr     <= acsp_pkg::ACSP_PWR_NORMAL;
      cal     <= 1'b0;
      rtgl    <= 1'b0;
      cap     <= '0;
    end
    else
    begin
      cs_prev <= next_cs_prev;
      active  <= next_active;
      cnt     <= next_cnt;
      hold    <= next_hold;
      trial   <= next_trial;
      res     <= next_res;
      sub_u   <= next_sub_u;
      sub_l   <= next_sub_l;
      sdo     <= next_sdo;
      oe      <= next_oe;
      cont    <= next_cont;
      pwr     <= next_pwr;
      cal     <= next_cal;
      rtgl    <= next_rtgl;
      cap     <= next_cap;
    end
  end

  // Link-side outputs straight from flip-flops, except ref_en_o, which is decoded from the power state.
  assign sdo_o    = sdo;
  assign sdo_oe_o = oe;
  assign hold_o   = hold;
  assign trial_o  = trial;
  assign ref_en_o = (pwr != acsp_pkg::ACSP_PWR_FULL);

  // System-domain crossing: toggle for results, two flops for levels.
  // Leaving full power-down flips both power bits, so that code waits for two agreeing samples.
  logic [2:0]                     tgl_sync, next_tgl_sync;
  logic [1:0]                     pwr_m, pwr_s;
  logic                           cal_m, cal_s;
  acsp_pkg::acsp_result_t         result, next_result;
  logic                           rvalid, next_rvalid;
  logic [1:0]                     pwr_q, next_pwr_q;

  // Result capture when the toggle edge arrives; cap is stable by then.
  always_comb
  begin
    next_tgl_sync = {tgl_sync[1:0], rtgl};
    next_rvalid   = tgl_sync[2] ^ tgl_sync[1];
    next_result   = next_rvalid ? cap : result;
    next_pwr_q    = (pwr_m == pwr_s) ? pwr_s : pwr_q;             // A skewed sample never agrees twice.
  end

  // System-domain registers.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      tgl_sync <= '0;
      pwr_m    <= '0;
      pwr_s    <= '0;
      pwr_q    <= '0;
      cal_m    <= 1'b0;
      cal_s    <= 1'b0;
      result   <= '0;
      rvalid   <= 1'b0;
    end
    else
    begin
      tgl_sync <= next_tgl_sync;
      pwr_m    <= pwr;
      pwr_s    <= pwr_m;
      pwr_q    <= next_pwr_q;
      cal_m    <= cal;
      cal_s    <= cal_m;
      result   <= next_result;
      rvalid   <= next_rvalid;
    end
  end

  // System-side outputs.
  assign result_o       = result;
  assign result_valid_o = rvalid;
  assign pwr_state_o    = acsp_pkg::acsp_pwr_t'(pwr_q);
  assign cal_done_o     = cal_s;

endmodule

/* acsp_port_props.sv */
// Checker of the serial conversion port, bound to its top module.
// Assumes the acsp_pkg types and the port names of acsp_port.
`timescale 1ns/1ps
module acsp_port_props
(
  input wire logic                mclk_i,
  input wire logic                rst_n_i,
  input wire logic                sclk_i,
  input wire logic                conv_start_n_i,
  input wire logic                comp_i,
  input wire logic                sdo_o,
  input wire logic                sdo_oe_o,
  input wire logic                hold_o,
  input wire logic                result_valid_o,
  input wire acsp_pkg::acsp_pwr_t pwr_state_o
);
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic       cs_q;
  logic       nrm;
  // Counts serial-clock rising edges since the last start, saturating.
  always_comb
  begin
    next_cnt = cnt;
    if (!conv_start_n_i && cs_q)
      next_cnt = 5'h01;
    else if (cnt != 5'h00 && cnt != 5'h1f)
      next_cnt = cnt + 5'h01;
  end
  // Registers the edge count and the previous convert-start level.
  always_ff @(posedge sclk_i)
  begin
    cs_q <= conv_start_n_i;
    cnt  <= rst_n_i ? next_cnt : 5'h00;
  end
  assign nrm = (pwr_state_o == acsp_pkg::ACSP_PWR_NORMAL);
  property p_start;
    @(posedge sclk_i) disable iff (!rst_n_i) (!conv_start_n_i && cs_q && nrm) |=> sdo_oe_o && !sdo_o && hold_o;
  endproperty
  a_start: assert property (p_start) else $error("start did not hold and drive low");
  property p_lead;
    @(posedge sclk_i) disable iff (!rst_n_i) (cnt >= 5'h01 && cnt <= 5'h03 && sdo_oe_o) |-> !sdo_o;
  endproperty
  a_lead: assert property (p_lead) else $error("leading slot not zero");
  property p_data;
    @(posedge sclk_i) disable iff (!rst_n_i) (cnt >= 5'h04 && cnt <= 5'h0d && sdo_oe_o && nrm) |-> sdo_o == $past(comp_i);
  endproperty
  a_data: assert property (p_data) else $error("data slot differs from decision");
  property p_trail;
    @(posedge sclk_i) disable iff (!rst_n_i) (cnt == 5'h10 && sdo_oe_o) |-> !sdo_o;
  endproperty
  a_trail: assert property (p_trail) else $error("trailing slot not zero");
  property p_track;
    @(posedge sclk_i) disable iff (!rst_n_i) (cnt == 5'h0e) |-> !hold_o;
  endproperty
  a_track: assert property (p_track) else $error("no tracking after edge 14");
  property p_release;
    @(posedge sclk_i) disable iff (!rst_n_i) (cnt == 5'h11 && !$past(conv_start_n_i)) |-> !sdo_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("output not released");
  property p_abort;
    @(posedge sclk_i) disable iff (!rst_n_i) (cnt >= 5'h04 && cnt <= 5'h0d && $past(conv_start_n_i)) |-> !sdo_oe_o;
  endproperty
  a_abort: assert property (p_abort) else $error("early abort kept output driven");
  property p_cont;
    @(posedge sclk_i) disable iff (!rst_n_i) (cnt == 5'h10 && $past(conv_start_n_i) && sdo_oe_o) |=> sdo_oe_o;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode dropped output");
  property p_valid;
    @(posedge mclk_i) disable iff (!rst_n_i) result_valid_o |=> !result_valid_o;
  endproperty
  a_valid: assert property (p_valid) else $error("result valid longer than one cycle");
endmodule

bind acsp_port acsp_port_props i_acsp_port_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
  .conv_start_n_i(conv_start_n_i), .comp_i(comp_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .hold_o(hold_o),
  .result_valid_o(result_valid_o), .pwr_state_o(pwr_state_o));

/* acsp_host_model.sv */
// Host model: serial clock, convert-start and a comparator answering the trials.
// Assumes a 48 ns serial clock that stands low outside frames.
`timescale 1ns/1ps
module acsp_host_model
(
  input  wire logic       sdo_i,
  input  wire logic       sdo_oe_i,
  input  wire logic [9:0] trial_i,
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic            comp_o
);
  logic [9:0] vin;
  logic       dout;
  // A trial bit is kept while the trial does not exceed the input.
  assign comp_o = (trial_i <= vin);
  // A released line reads as the inverse of sdo_i, which an abort clears to 0 as it releases.
  assign dout = sdo_oe_i ? sdo_i : ~sdo_i;
  // Idle: clock low, converter armed.
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    vin    = 10'h000;
  end
  // Runs n clock cycles with convert-start held at level cs.
  task automatic clocks(input int n, input logic cs);
    cs_n_o = cs;
    repeat (n)
    begin
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
  endtask
  // One frame of n edges at a 48 ns period; convert-start rises at edge rise_at; bits taken at falls.
  // The convert-start fall splits the first low phase, so the period stays 48 ns.
  task automatic frame(input int rise_at, input int n, input logic [9:0] v, output logic [15:0] bits);
    vin = v;
    bits = 16'h0000;
    #6 cs_n_o = 1'b0;
    for (int e = 1; e <= n; e++)
    begin
      #((e == 1) ? 18 : 24) sclk_o = 1'b1;
      if (e == rise_at) cs_n_o <= 1'b1;
      #24 sclk_o = 1'b0;
      bits = {bits[14:0], dout};
    end
  endtask
endmodule

/* adc_serial_conversion_port_tb_top.sv */
// Testbench of the serial conversion port: single, continuous and power-down frames.
// Assumes acsp_host_model drives the link side and the checker is bound.
`timescale 1ns/1ps
module adc_serial_conversion_port_tb_top;
  logic                   mclk = 1'b0;
  logic                   rst_n;
  logic                   sclk, cs_n, comp, sdo, sdo_oe, hold, ref_en, res_valid, cal_done;
  logic [9:0]             trial;
  logic [15:0]            bits;
  acsp_pkg::acsp_result_t result, last_res;
  acsp_pkg::acsp_pwr_t    pwr;
  int                     num_errors = 0;
  int                     comparisons = 0;
  int                     cycles = 0;
  acsp_port i_acsp_port (.mclk_i(mclk), .rst_n_i(rst_n), .sclk_i(sclk), .conv_start_n_i(cs_n), .comp_i(comp),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .hold_o(hold), .trial_o(trial), .ref_en_o(ref_en), .result_o(result),
    .result_valid_o(res_valid), .pwr_state_o(pwr), .cal_done_o(cal_done));
  acsp_host_model i_acsp_host_model (.sdo_i(sdo), .sdo_oe_i(sdo_oe), .trial_i(trial), .sclk_o(sclk),
    .cs_n_o(cs_n), .comp_o(comp));
  // System clock, result capture away from the launching edge, and hang limit.
  always #20 mclk = ~mclk;
  always @(negedge mclk)
  begin
    if (res_valid === 1'b1) last_res <= result;
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge mclk);
  endtask
  task automatic t_single();
    chk("hold_reset", 16'h0000, 16'(hold));
    i_acsp_host_model.frame(0, 16, 10'h2a5, bits);
    chk("frame", {3'b000, 10'h2a5, 3'b000}, bits & 16'hfff9);
    chk("track", 16'h0000, 16'(hold));
    i_acsp_host_model.clocks(1, 1'b0);
    chk("release", 16'h0000, 16'(sdo_oe));
    i_acsp_host_model.clocks(2, 1'b1);
    settle();
    chk("result", 16'h02a5, 16'(last_res.data));
    chk("cal_done", 16'h0001, 16'(cal_done));
  endtask
  task automatic t_cont();
    i_acsp_host_model.frame(15, 16, 10'h155, bits);
    chk("cont_first", {3'b000, 10'h155, 3'b000}, bits & 16'hfff9);
    i_acsp_host_model.frame(15, 16, 10'h3ff, bits);
    chk("cont_frame", {3'b000, 10'h3ff, 3'b000}, bits & 16'hfff9);
    i_acsp_host_model.clocks(1, 1'b1);
    chk("cont_oe", 16'h0001, 16'(sdo_oe));
    i_acsp_host_model.clocks(1, 1'b1);
    settle();
    chk("cont_result", 16'h03ff, 16'(last_res.data));
  endtask
  task automatic t_pd();
    i_acsp_host_model.frame(5, 6, 10'h100, bits);
    chk("abort_oe", 16'h0000, 16'(sdo_oe));
    settle();
    chk("partial", 16'(acsp_pkg::ACSP_PWR_PARTIAL), 16'(pwr));
    chk("ref_partial", 16'h0001, 16'(ref_en));
    i_acsp_host_model.frame(5, 6, 10'h100, bits);
    settle();
    chk("full", 16'(acsp_pkg::ACSP_PWR_FULL), 16'(pwr));
    chk("ref_full", 16'h0000, 16'(ref_en));
    i_acsp_host_model.frame(15, 16, 10'h0aa, bits);
    i_acsp_host_model.clocks(2, 1'b1);
    settle();
    chk("wake", 16'(acsp_pkg::ACSP_PWR_NORMAL), 16'(pwr));
    chk("ref_wake", 16'h0001, 16'(ref_en));
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset with the serial clock running, then the scenarios.
  initial
  begin
    rst_n <= 1'b0;
    fork
      i_acsp_host_model.clocks(8, 1'b1);
      repeat (20) @(posedge mclk);
    join
    rst_n <= 1'b1;
    i_acsp_host_model.clocks(4, 1'b1);
    t_single();
    t_cont();
    t_pd();
    report_and_stop();
  end
endmodule
